// >>> shared/hvsi_pkg.sv
// Purpose: Shared constants for the high-voltage sense pin interlock
// Assumes: 20 MHz single clock, plain register port with word indices
// Notes:   Offsets are register indices on the plain port

package hvsi_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned WAKE_FILT_NS   = 16000;
    localparam int unsigned WAKE_FILT_CYC  = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Register indices
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL        = 4'h0;
    localparam logic [3:0] REG_PIN_CFG     = 4'h1;
    localparam logic [3:0] REG_PULL_CFG    = 4'h2;
    localparam logic [3:0] REG_WAKE_EVT    = 4'h3;
    localparam logic [3:0] REG_WAKE_LVL    = 4'h4;
    localparam logic [3:0] REG_FAIL_STAT   = 4'h5;
    localparam logic [3:0] REG_IRQ_STAT    = 4'h6;
    localparam logic [3:0] REG_IRQ_MASK    = 4'h7;
    localparam logic [3:0] REG_MODE_CMD    = 4'h8;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned CTRL_SENSE_BIT   = 0;
    localparam int unsigned CTRL_FOTEST_BIT  = 1;
    localparam int unsigned MODE_SLEEP_BIT   = 0;
    localparam int unsigned IRQ_HV_WAKE_BIT  = 0;
    localparam int unsigned IRQ_PIN_WAKE_BIT = 1;
    localparam int unsigned IRQ_CMD_FAIL_BIT = 2;
    localparam int unsigned IRQ_RESTART_BIT  = 3;
    localparam int unsigned IRQ_W            = 4;

    // ----------------------------------------------------------------
    // Pin configuration codes and reset values
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PIN_FAIL_OUT = 3'h0,
        PIN_HS_CYCL  = 3'h3,
        PIN_OFF      = 3'h4,
        PIN_WAKE_IN  = 3'h5,
        PIN_LOW_SIDE = 3'h6,
        PIN_HIGH_SIDE= 3'h7
    } hvsi_pin_cfg_t;

    typedef enum logic [1:0] {
        PULL_NONE = 2'h0,
        PULL_DOWN = 2'h1,
        PULL_UP   = 2'h2,
        PULL_AUTO = 2'h3
    } hvsi_pull_t;

    localparam logic [2:0] PIN_CFG_RST  = 3'h0;
    localparam logic [1:0] PULL_CFG_RST = 2'h0;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

endpackage

// >>> hw/hvsi_pin_filter.sv
// Purpose: Two-stage synchroniser plus stability filter for a pin level
// Assumes: Pin is asynchronous to clk_i
// Notes:   Output changes only after the input held steady FILT_CYC cycles

`timescale 1ns/1ps
`default_nettype none

module hvsi_pin_filter #(
    parameter int unsigned FILT_CYC = 320
) (
    input  wire logic clk_i,    // Clock
    input  wire logic rst_i,    // Sync reset
    input  wire logic pin_i,    // Raw pin level
    input  wire logic enable_i, // Filter running
    output logic      level_o   // Filtered level
);
    localparam int unsigned CW = $clog2(FILT_CYC + 1);

    logic          meta_q;
    logic          sync_q;
    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    // Count stable cycles of a differing level
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_i || sync_q == level_o) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
        end else if (enable_i && sync_q != level_o && cnt_q == CW'(FILT_CYC - 1)) begin
            level_o <= sync_q;
        end
    end

endmodule

`default_nettype wire

// >>> hw/hvsi_sticky.sv
// Purpose: Sticky status bits with read-clear
// Assumes: Set and clear come from the same clock
// Notes:   A set in the clearing cycle wins

`timescale 1ns/1ps
`default_nettype none

module hvsi_sticky #(
    parameter int unsigned W = 2
) (
    input  wire logic         clk_i, // Clock
    input  wire logic         rst_i, // Sync reset
    input  wire logic [W-1:0] set_i, // Event pulses
    input  wire logic         clr_i, // Read clear
    output logic      [W-1:0] q_o    // Sticky bits
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= '0;
        end else begin
            q_o <= (clr_i ? '0 : q_o) | set_i;
        end
    end

endmodule

`default_nettype wire

// >>> hw/hvsi_interlock.sv
// Purpose: Interlock that turns the wake and fail/GPIO pins into a sense route
// Assumes: Single 20 MHz clock, plain register port, pins asynchronous
// Notes:   Refused sense enables, fail-test requests and non-PIN_OFF pin writes in sense mode, and restart entries raise the command-failure flag

`timescale 1ns/1ps
`default_nettype none

module hvsi_interlock
    import hvsi_pkg::*;
#(
    parameter int unsigned FILT_CYC = WAKE_FILT_CYC
) (
    input  wire logic       clk_i,             // Clock, 20 MHz
    input  wire logic       rst_i,             // Sync reset, active high
    input  wire logic [3:0] addr_i,            // Register index
    input  wire logic [7:0] wdata_i,           // Write data
    input  wire logic       wr_i,              // Write strobe
    input  wire logic       rd_i,              // Read strobe
    output logic      [7:0] rdata_o,           // Read data, next cycle
    input  wire logic       hv_wake_pin_i,     // Wake comparator level
    input  wire logic       gpio_pin_i,        // Fail/GPIO pin level
    input  wire logic       failure_i,         // Device failure level
    input  wire logic       other_wake_i,      // Another wake source armed
    output logic            sense_route_o,     // Wake voltage routed to pin
    output logic            fail_out_drive_o,  // Fail output pulls pin low
    output logic            gpio_func_en_o,    // GPIO switch function allowed
    output logic      [2:0] gpio_func_o,       // Active GPIO configuration
    output logic            wake_pull_up_o,    // Wake pull-up enabled
    output logic            wake_pull_down_o,  // Wake pull-down enabled
    output logic            hv_wake_o,         // Internal wake signal
    output logic            sleep_enter_o,     // Sleep entry pulse
    output logic            restart_enter_o,   // Restart entry pulse
    output logic            irq_o              // Interrupt level
);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic                sense_en_q;
    logic                fo_test_q;
    hvsi_pin_cfg_t       pin_cfg_q;
    hvsi_pull_t          pull_cfg_q;
    logic [IRQ_W-1:0]    irq_mask_q;

    logic wr_ctrl;
    logic wr_pin;
    logic wr_pull;
    logic wr_mask;
    logic wr_mode;
    logic req_sense;
    logic req_fotest;
    logic sense_refused;
    logic fotest_refused;
    logic pin_refused;
    logic cmd_fail;

    assign wr_ctrl    = wr_i && addr_i == REG_CTRL;
    assign wr_pin     = wr_i && addr_i == REG_PIN_CFG;
    assign wr_pull    = wr_i && addr_i == REG_PULL_CFG;
    assign wr_mask    = wr_i && addr_i == REG_IRQ_MASK;
    assign wr_mode    = wr_i && addr_i == REG_MODE_CMD;
    assign req_sense  = wdata_i[CTRL_SENSE_BIT];
    assign req_fotest = wdata_i[CTRL_FOTEST_BIT];

    // Setting sense mode with the pin still a fail output
    assign sense_refused  = wr_ctrl && req_sense && !sense_en_q
                            && pin_cfg_q == PIN_FAIL_OUT;
    // Fail output test is unavailable in sense mode
    assign fotest_refused = wr_ctrl && req_fotest && sense_en_q;
    // Pin configuration frozen in sense mode
    assign pin_refused    = wr_pin && sense_en_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sense_en_q <= 1'b0;
        end else if (wr_ctrl && !sense_refused) begin
            sense_en_q <= req_sense;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fo_test_q <= 1'b0;
        end else if (wr_ctrl) begin
            fo_test_q <= req_fotest && !sense_en_q && !(req_sense && !sense_refused);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_cfg_q <= hvsi_pin_cfg_t'(PIN_CFG_RST);
        end else if (wr_pin && !pin_refused) begin
            pin_cfg_q <= hvsi_pin_cfg_t'(wdata_i[2:0]);
        end
    end

    // Pull setting always stored, applied only outside sense mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pull_cfg_q <= hvsi_pull_t'(PULL_CFG_RST);
        end else if (wr_pull) begin
            pull_cfg_q <= hvsi_pull_t'(wdata_i[1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_q <= IRQ_MASK_RST;
        end else if (wr_mask) begin
            irq_mask_q <= wdata_i[IRQ_W-1:0];
        end
    end

    // Refused sense enable, fail-test or non-PIN_OFF pin write in sense mode, or a restart entry
    assign cmd_fail = sense_refused || fotest_refused
                      || (pin_refused && wdata_i[2:0] != PIN_OFF)
                      || restart_enter_o;

    // ------------------------------------------------------------------
    // Pin routing and gating
    // ------------------------------------------------------------------
    logic hv_level;
    logic gpio_level;
    logic gpio_is_wake;

    assign gpio_is_wake = pin_cfg_q == PIN_WAKE_IN && !sense_en_q;

    hvsi_pin_filter #(
        .FILT_CYC (FILT_CYC)
    ) u_hv_filt (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .pin_i    (hv_wake_pin_i),
        .enable_i (!sense_en_q),
        .level_o  (hv_level)
    );

    hvsi_pin_filter #(
        .FILT_CYC (FILT_CYC)
    ) u_gpio_filt (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .pin_i    (gpio_pin_i),
        .enable_i (gpio_is_wake),
        .level_o  (gpio_level)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sense_route_o <= 1'b0;
        end else begin
            sense_route_o <= sense_en_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fail_out_drive_o <= 1'b0;
        end else begin
            fail_out_drive_o <= !sense_en_q && pin_cfg_q == PIN_FAIL_OUT
                                && (failure_i || fo_test_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gpio_func_en_o <= 1'b0;
            gpio_func_o    <= PIN_CFG_RST;
        end else begin
            gpio_func_en_o <= !sense_en_q && pin_cfg_q != PIN_FAIL_OUT
                              && pin_cfg_q != PIN_OFF;
            gpio_func_o    <= sense_en_q ? PIN_OFF : pin_cfg_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_pull_up_o   <= 1'b0;
            wake_pull_down_o <= 1'b0;
        end else begin
            wake_pull_up_o   <= !sense_en_q && pull_cfg_q == PULL_UP;
            wake_pull_down_o <= !sense_en_q && pull_cfg_q == PULL_DOWN;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hv_wake_o <= 1'b0;
        end else begin
            hv_wake_o <= hv_level && !sense_en_q;
        end
    end

    // ------------------------------------------------------------------
    // Wake level and event status
    // ------------------------------------------------------------------
    logic       hv_prev_q;
    logic       gpio_prev_q;
    logic [1:0] wake_lvl_q;
    logic [1:0] wake_evt;
    logic [1:0] wake_evt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hv_prev_q   <= 1'b0;
            gpio_prev_q <= 1'b0;
        end else begin
            hv_prev_q   <= hv_level;
            gpio_prev_q <= gpio_level;
        end
    end

    assign wake_evt[0] = !sense_en_q && hv_level != hv_prev_q;
    assign wake_evt[1] = gpio_is_wake && gpio_level != gpio_prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_lvl_q <= 2'h0;
        end else if (!sense_en_q) begin
            wake_lvl_q <= {gpio_level, hv_level};
        end
    end

    hvsi_sticky #(
        .W (2)
    ) u_wake_evt (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (wake_evt),
        .clr_i (rd_i && addr_i == REG_WAKE_EVT),
        .q_o   (wake_evt_q)
    );

    // ------------------------------------------------------------------
    // Command failure flag
    // ------------------------------------------------------------------
    logic [0:0] fail_q;

    hvsi_sticky #(
        .W (1)
    ) u_fail (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (cmd_fail),
        .clr_i (rd_i && addr_i == REG_FAIL_STAT),
        .q_o   (fail_q)
    );

    // ------------------------------------------------------------------
    // Sleep request handling
    // ------------------------------------------------------------------
    logic sleep_req;
    logic sleep_bad;

    assign sleep_req = wr_mode && wdata_i[MODE_SLEEP_BIT];
    // Wake pin gated in sense mode, GPIO wake alone cannot wake
    assign sleep_bad = pin_cfg_q == PIN_WAKE_IN && sense_en_q && !other_wake_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_enter_o   <= 1'b0;
            restart_enter_o <= 1'b0;
        end else begin
            sleep_enter_o   <= sleep_req && !sleep_bad;
            restart_enter_o <= sleep_req && sleep_bad;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_stat_q;

    assign irq_set = {restart_enter_o, cmd_fail, wake_evt[1], wake_evt[0]};

    hvsi_sticky #(
        .W (IRQ_W)
    ) u_irq (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (irq_set),
        .clr_i (rd_i && addr_i == REG_IRQ_STAT),
        .q_o   (irq_stat_q)
    );

    assign irq_o = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        unique case (addr_i)
            REG_CTRL:      rd_mux = {6'h00, fo_test_q, sense_en_q};
            REG_PIN_CFG:   rd_mux = {5'h00, pin_cfg_q};
            REG_PULL_CFG:  rd_mux = {6'h00, pull_cfg_q};
            REG_WAKE_EVT:  rd_mux = {6'h00, wake_evt_q};
            REG_WAKE_LVL:  rd_mux = {6'h00, wake_lvl_q};
            REG_FAIL_STAT: rd_mux = {7'h00, fail_q};
            REG_IRQ_STAT:  rd_mux = {4'h0, irq_stat_q};
            REG_IRQ_MASK:  rd_mux = {4'h0, irq_mask_q};
            default:       rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rd_mux;
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// >>> bench/hvsi_interlock_asserts.sv
// Purpose: Port checker for the sense pin interlock
// Assumes: Single clock, sync reset
// Notes:   Bound into hvsi_interlock
`timescale 1ns/1ps
`default_nettype none
module hvsi_interlock_asserts
    import hvsi_pkg::*;
(
    input wire logic       clk_i,            // Clock
    input wire logic       rst_i,            // Sync reset
    input wire logic [3:0] addr_i,           // Register index
    input wire logic [7:0] wdata_i,          // Write data
    input wire logic       wr_i,             // Write strobe
    input wire logic       rd_i,             // Read strobe
    input wire logic [7:0] rdata_o,          // Read data
    input wire logic       other_wake_i,     // Other wake armed
    input wire logic       sense_route_o,    // Sense route
    input wire logic       fail_out_drive_o, // Fail drive
    input wire logic       gpio_func_en_o,   // GPIO enable
    input wire logic [2:0] gpio_func_o,      // GPIO config
    input wire logic       wake_pull_up_o,   // Pull-up
    input wire logic       wake_pull_down_o, // Pull-down
    input wire logic       hv_wake_o,        // Wake signal
    input wire logic       sleep_enter_o,    // Sleep pulse
    input wire logic       restart_enter_o   // Restart pulse
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sense_blocks_a: assert property (
        sense_route_o |-> gpio_func_o == PIN_OFF && !fail_out_drive_o && !gpio_func_en_o
            && !wake_pull_up_o && !wake_pull_down_o && !hv_wake_o)
        else $error("pin function active in sense mode");
    route_cause_a: assert property (
        $rose(sense_route_o) |-> $past(wr_i, 2) && $past(addr_i, 2) == REG_CTRL
            && $past(wdata_i[0], 2))
        else $error("sense route rose without enable write");
    fo_drive_a: assert property (
        fail_out_drive_o |-> gpio_func_o == PIN_FAIL_OUT && !sense_route_o)
        else $error("fail output driven outside its mode");
    pin_hold_a: assert property (
        $changed(gpio_func_o) && !sense_route_o && !$past(sense_route_o)
            |-> $past(wr_i, 2) && $past(addr_i, 2) == REG_PIN_CFG)
        else $error("pin function changed without config write");
    sleep_answer_a: assert property (
        wr_i && addr_i == REG_MODE_CMD && wdata_i[MODE_SLEEP_BIT]
            |=> sleep_enter_o != restart_enter_o)
        else $error("sleep request got no single answer");
    sleep_cause_a: assert property (
        sleep_enter_o || restart_enter_o |-> $past(wr_i) && $past(addr_i) == REG_MODE_CMD)
        else $error("mode pulse without sleep request");
    restart_other_a: assert property (
        restart_enter_o |-> !$past(other_wake_i))
        else $error("restart although another wake source armed");
    rdata_idle_a: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read answer cycle");

    cover property ($rose(sense_route_o));
    cover property (restart_enter_o);
    cover property (sleep_enter_o);
endmodule

bind hvsi_interlock hvsi_interlock_asserts i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .other_wake_i(other_wake_i),
    .sense_route_o(sense_route_o), .fail_out_drive_o(fail_out_drive_o),
    .gpio_func_en_o(gpio_func_en_o), .gpio_func_o(gpio_func_o),
    .wake_pull_up_o(wake_pull_up_o), .wake_pull_down_o(wake_pull_down_o),
    .hv_wake_o(hv_wake_o), .sleep_enter_o(sleep_enter_o), .restart_enter_o(restart_enter_o)
);
`default_nettype wire

// >>> bench/hvsi_host_model.sv
// Purpose: Host model issuing register accesses
// Assumes: Read data stands one cycle after the strobe
// Notes:   Signals change by non-blocking assignment after an edge
`timescale 1ns/1ps
`default_nettype none
module hvsi_host_model (
    input  wire logic       clk_i,   // Clock
    input  wire logic [7:0] rdata_i, // Read data
    output logic      [3:0] addr_o,  // Register index
    output logic      [7:0] wdata_o, // Write data
    output logic            wr_o,    // Write strobe
    output logic            rd_o     // Read strobe
);
    initial begin
        addr_o = 4'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// >>> bench/tb_hv_sense_pin_interlock.sv
// Purpose: Self-checking bench for the sense pin interlock
// Assumes: Short wake filter for simulation
// Notes:   Random pin and pull settings from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_hv_sense_pin_interlock;
    import hvsi_pkg::*;
    localparam int unsigned FC = 8;
    logic clk_i, rst_i, hv_pin, gp_pin, fail_lvl, oth, wr, rd, sense, fo, gen, pu, pd;
    logic hvw, slp, rse, irq, t;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, rv;
    logic [2:0]  gfn, c;
    logic [1:0]  p;
    logic [31:0] lfsr_q;
    logic [2:0]  codes [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    int          mismatches, checks;

    hvsi_host_model h (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    hvsi_interlock #(.FILT_CYC(FC)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .hv_wake_pin_i(hv_pin), .gpio_pin_i(gp_pin),
        .failure_i(fail_lvl), .other_wake_i(oth), .sense_route_o(sense),
        .fail_out_drive_o(fo), .gpio_func_en_o(gen), .gpio_func_o(gfn),
        .wake_pull_up_o(pu), .wake_pull_down_o(pd), .hv_wake_o(hvw),
        .sleep_enter_o(slp), .restart_enter_o(rse), .irq_o(irq));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        h.rd(a, rv);
        chk("register read", rv, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_i, hv_pin, gp_pin, fail_lvl, oth} = 5'b10000;
        {mismatches, checks} = 0;
        lfsr_q = 32'hF8361B04;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(1);
        chk("func reset", gfn, 8'h00);
        rchk(REG_PIN_CFG, 8'(PIN_CFG_RST));
        rchk(REG_IRQ_MASK, 8'(IRQ_MASK_RST));
        h.wr(4'hF, 8'hFF);
        rchk(4'hF, 8'h00);
        @(posedge clk_i) fail_lvl <= 1'b1;
        settle(3);
        chk("fail drive", fo, 8'h01);
        $display("test reset done");
        h.wr(REG_IRQ_MASK, 8'h04);
        h.wr(REG_CTRL, 8'h01);
        settle(2);
        chk("route refused", sense, 8'h00);
        chk("irq raised", irq, 8'h01);
        rchk(REG_FAIL_STAT, 8'h01);
        rchk(REG_FAIL_STAT, 8'h00);
        rchk(REG_IRQ_STAT, 8'h04);
        chk("irq cleared", irq, 8'h00);
        $display("test refuse done");
        h.wr(REG_PIN_CFG, 8'(PIN_OFF));
        h.wr(REG_CTRL, 8'h01);
        settle(2);
        chk("route on", sense, 8'h01);
        chk("fail drive off", fo, 8'h00);
        foreach (codes[i]) begin
            h.wr(REG_PIN_CFG, 8'(codes[i]));
            rchk(REG_FAIL_STAT, 8'(codes[i] != PIN_OFF));
        end
        rchk(REG_PIN_CFG, 8'(PIN_OFF));
        h.wr(REG_CTRL, 8'h03);
        rchk(REG_FAIL_STAT, 8'h01);
        rchk(REG_CTRL, 8'h01);
        for (int i = 0; i < 5; i++) begin
            h.wr(REG_PULL_CFG, 8'(i % 4 == 0 ? 2 : i % 4));
            rchk(REG_PULL_CFG, 8'(i % 4 == 0 ? 2 : i % 4));
            chk("pulls off", {pu, pd}, 8'h00);
        end
        @(posedge clk_i) hv_pin <= 1'b1;
        settle(FC + 8);
        chk("wake gated", hvw, 8'h00);
        rchk(REG_WAKE_EVT, 8'h00);
        rchk(REG_WAKE_LVL, 8'h00);
        $display("test sense done");
        h.wr(REG_CTRL, 8'h00);
        h.wr(REG_PIN_CFG, 8'(PIN_WAKE_IN));
        for (int i = 0; i < 40 && hvw !== 1'b1; i++) settle(1);
        chk("wake back", hvw, 8'h01);
        chk("pull up back", pu, 8'h01);
        h.rd(REG_WAKE_EVT, rv);
        @(posedge clk_i) gp_pin <= 1'b1;
        repeat (FC - 2) @(posedge clk_i);
        gp_pin <= 1'b0;
        settle(FC + 6);
        rchk(REG_WAKE_EVT, 8'h00);
        @(posedge clk_i) gp_pin <= 1'b1;
        settle(FC + 6);
        rchk(REG_WAKE_EVT, 8'h02);
        h.rd(REG_WAKE_LVL, rv);
        chk("gpio level", rv & 8'h02, 8'h02);
        h.wr(REG_CTRL, 8'h01);
        h.wr(REG_MODE_CMD, 8'h01);
        #1;
        chk("restart", {slp, rse}, 8'h01);
        rchk(REG_FAIL_STAT, 8'h01);
        h.rd(REG_IRQ_STAT, rv);
        chk("irq restart", rv & 8'h0C, 8'h0C);
        @(posedge clk_i) oth <= 1'b1;
        h.wr(REG_MODE_CMD, 8'h01);
        #1;
        chk("sleep", {slp, rse}, 8'h02);
        h.wr(REG_CTRL, 8'h00);
        $display("test sleep done");
        for (int n = 0; n < 12; n++) begin
            lfsr_q = lfsr(lfsr_q);
            c = codes[lfsr_q % 6];
            p = lfsr_q[9:8];
            t = lfsr_q[1];
            @(posedge clk_i) fail_lvl <= lfsr_q[0];
            h.wr(REG_CTRL, {6'h00, t, 1'b0});
            h.wr(REG_PIN_CFG, 8'(c));
            h.wr(REG_PULL_CFG, 8'(p));
            settle(3);
            chk("func", gfn, 8'(c));
            chk("func en", gen, 8'(c != PIN_FAIL_OUT && c != PIN_OFF));
            chk("fail drive", fo, 8'(c == PIN_FAIL_OUT && (lfsr_q[0] || t)));
            chk("pulls", {pu, pd}, 8'(p == 2'h2 ? 2 : p == 2'h1 ? 1 : 0));
        end
        $display("test random done");
        h.wr(REG_PIN_CFG, 8'(PIN_FAIL_OUT));
        h.wr(REG_IRQ_MASK, 8'h00);
        h.wr(REG_CTRL, 8'h01);
        settle(2);
        chk("masked irq", irq, 8'h00);
        chk("route refused", sense, 8'h00);
        chk("wake before reset", hvw, 8'h01);
        @(posedge clk_i) rst_i <= 1'b1;
        settle(2);
        chk("func reset", gfn, 8'h00);
        chk("outputs reset", {sense, fo, gen, pu, pd, hvw, irq, rse}, 8'h00);
        $display("test final done");
        conclude();
    end
endmodule
`default_nettype wire
